// ### sts_selftest_supervisor.sv
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "sts_params.svh"
//Contract
// - any disabling failure turns off overcurrent and trip/close decisions
// - while protection is off, contact, trip and close drives stay off
// - while protection is off, the enabled indicator is dark
// - alarm is shown by de-energising the alarm coil
// - warnings pulse the coil off five seconds; failures latch it off
// - every warning or failure raises an unsolicited status report
// - every failure shows a display message; warnings do not
// - offsets every 10 s: channel or master warn, master 30 mV fails
// - +5 V rail every 10 s with warning and failing windows
// - 12 V rails every 10 s with warning and failing windows
// - 15 V rails every 10 s with warning and failing windows
// - battery outside 18 to 45 V warns, protection stays on
// - RAM write-then-read test every 60 s; mismatch fails
// - program checksum every 10 s; mismatch fails
// - active settings checksum every 10 s; mismatch fails
// - stored settings checksum every 10 s; mismatch fails
// - each quarter cycle after the first mark past reset, too few conversions fails
// - stopped crystal fails and shows the halt message
// - trap or bad access fails and shows the trap code
// - charger processor error warns, protection stays on
module sts_selftest_supervisor
  import sts_pkg::*;
#(
  parameter int unsigned CHECK_CYCLES = `STS_CHECK_PERIOD_S * `STS_CLK_HZ,
  parameter int unsigned PULSE_CYCLES = `STS_ALARM_PULSE_S * `STS_CLK_HZ,
  parameter int unsigned RAM_TICKS = `STS_RAM_PERIOD_S / `STS_CHECK_PERIOD_S,
  parameter int unsigned CONV_PER_QTR = `STS_CONV_PER_QTR,
  parameter int unsigned NCHAN = `STS_NCHAN,
  parameter int unsigned NCONT = `STS_NCONT,
  parameter int unsigned RAM_DEPTH = `STS_RAM_DEPTH
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [`STS_ADDR_W-1:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  input wire logic [NCHAN-1:0][15:0] chan_offset_uv_in,
  input wire logic [15:0] master_offset_uv_in,
  input wire logic [15:0] p5_mv_in,
  input wire logic [15:0] p12_mv_in,
  input wire logic [15:0] n12_mv_in,
  input wire logic [15:0] p15_mv_in,
  input wire logic [15:0] n15_mv_in,
  input wire logic [15:0] batt_mv_in,
  input wire logic [15:0] rom_sum_in,
  input wire logic [15:0] rom_ref_in,
  input wire logic [15:0] active_settings_checksum_in,
  input wire logic [15:0] active_settings_ref_in,
  input wire logic [15:0] nv_settings_checksum_in,
  input wire logic [15:0] nv_settings_ref_in,
  input wire logic conv_done_in,
  input wire logic quarter_cycle_in,
  input wire logic osc_probe_in,
  input wire logic trap_valid_in,
  input wire logic [7:0] trap_code_in,
  input wire logic charger_err_in,
  input wire logic trip_req_in,
  input wire logic close_req_in,
  input wire logic [NCONT-1:0] contact_req_in,
  output logic prot_en_out,
  output logic trip_drive_out,
  output logic close_drive_out,
  output logic [NCONT-1:0] contact_drive_out,
  output logic en_led_out,
  output logic alarm_coil_out,
  output logic report_out,
  output logic disp_valid_out,
  output sts_msg_t disp_kind_out,
  output logic [7:0] disp_arg_out
);
  localparam int unsigned XTAL_CYCLES =
    (`STS_XTAL_TIMEOUT_NS + `STS_CLK_PERIOD_NS - 1) / `STS_CLK_PERIOD_NS;
  localparam int unsigned AW = $clog2(RAM_DEPTH);
  localparam int PULSE_MIN = PULSE_CYCLES;
  if (NCHAN < 1 || NCONT < 1 || RAM_DEPTH < 2 || RAM_TICKS < 1 ||
      CONV_PER_QTR < 1 || CONV_PER_QTR > 255 || PULSE_CYCLES < 1) begin : g_bad
    $error("sts_selftest_supervisor: unsupported parameter value");
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic outside(input logic [15:0] v, input logic [15:0] lo,
                                   input logic [15:0] hi);
    return (v < lo) || (v > hi);
  endfunction : outside

  function automatic logic [15:0] pattern(input logic [AW-1:0] a, input logic seed);
    return (seed ? `STS_SEED_A : `STS_SEED_B) ^ 16'(a);
  endfunction : pattern

  function automatic logic [7:0] lowest(input logic [15:0] v);
    logic [7:0] idx;
    idx = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        idx = 8'(i);
      end
    end
    return idx;
  endfunction : lowest

  // ****************************************
  // ten second check tick
  // ****************************************
  sts_tick_if tick10_if ();
  sts_divider #(.DIV(CHECK_CYCLES)) u_tick10 (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .tick_if(tick10_if)
  );

  // ****************************************
  // state
  // ****************************************
  logic [15:0] warn_q, warn_d, fail_q, fail_d;
  logic force_q, force_d;
  logic [7:0] trap_q, trap_d;
  logic [31:0] rd_q, rd_d;
  logic [31:0] alarm_cnt_q, alarm_cnt_d;
  logic [7:0] conv_cnt_q, conv_cnt_d;
  logic conv_arm_q, conv_arm_d;
  logic [15:0] xtal_cnt_q, xtal_cnt_d;
  logic osc_prev_q, osc_prev_d;
  logic prot_q, prot_d, trip_q, trip_d, close_q, close_d, led_q, led_d;
  logic coil_q, coil_d, report_q, report_d, dvalid_q, dvalid_d;
  logic [NCONT-1:0] cont_q, cont_d;
  sts_msg_t dkind_q, dkind_d;
  logic [7:0] darg_q, darg_d;
  sts_ram_state_t ram_st_q, ram_st_d;
  logic [AW-1:0] ram_addr_q, ram_addr_d;
  logic ram_seed_q, ram_seed_d, ram_bad;
  logic [7:0] ram_tick_q, ram_tick_d;
  logic [15:0] mem [RAM_DEPTH];
  logic check_now, conv_short, xtal_stop;
  logic [15:0] warn_set, fail_set, warn_clr, new_fail;
  logic [NCHAN-1:0] chan_hi;

  // per-channel offset compare
  for (genvar g = 0; g < NCHAN; g++) begin : g_chan
    assign chan_hi[g] = chan_offset_uv_in[g] > `STS_OFS_CHAN_WARN_UV;
  end

  // ****************************************
  // continuous monitors
  // ****************************************
  // conversions since the last quarter mark, crystal silence counter
  always_comb begin
    // the window ending at the first mark after reset is partial, so it is not judged
    conv_arm_d = conv_arm_q | quarter_cycle_in;
    conv_short = conv_arm_q && quarter_cycle_in &&
                 (10'(conv_cnt_q) + 10'(conv_done_in) < 10'(CONV_PER_QTR));
    if (quarter_cycle_in) begin
      conv_cnt_d = 8'h00;
    end else if (conv_done_in && conv_cnt_q != 8'hFF) begin
      conv_cnt_d = conv_cnt_q + 8'h01;
    end else begin
      conv_cnt_d = conv_cnt_q;
    end
    osc_prev_d = osc_probe_in;
    xtal_stop = (xtal_cnt_q == 16'(XTAL_CYCLES));
    if (osc_probe_in != osc_prev_q) begin
      xtal_cnt_d = 16'h0000;
    end else if (!xtal_stop) begin
      xtal_cnt_d = xtal_cnt_q + 16'h0001;
    end else begin
      xtal_cnt_d = xtal_cnt_q;
    end
  end

  // ****************************************
  // memory walk test
  // ****************************************
  // successive runs alternate opposite seeds, so two runs catch stuck bits in either polarity
  always_comb begin
    ram_st_d = ram_st_q;
    ram_addr_d = ram_addr_q;
    ram_seed_d = ram_seed_q;
    ram_tick_d = ram_tick_q;
    ram_bad = 1'b0;
    if (tick10_if.tick) begin
      ram_tick_d = (ram_tick_q == 8'(RAM_TICKS - 1)) ? 8'h00 : ram_tick_q + 8'h01;
    end
    unique case (ram_st_q)
      STS_RAM_IDLE: begin
        if (tick10_if.tick && ram_tick_q == 8'(RAM_TICKS - 1)) begin
          ram_st_d = STS_RAM_WRITE;
          ram_addr_d = '0;
          ram_seed_d = ~ram_seed_q;
        end
      end
      STS_RAM_WRITE: begin
        ram_addr_d = ram_addr_q + 1'b1;
        if (ram_addr_q == AW'(RAM_DEPTH - 1)) begin
          ram_st_d = STS_RAM_READ;
          ram_addr_d = '0;
        end
      end
      STS_RAM_READ: begin
        ram_bad = (mem[ram_addr_q] != pattern(ram_addr_q, ram_seed_q));
        ram_addr_d = ram_addr_q + 1'b1;
        if (ram_addr_q == AW'(RAM_DEPTH - 1)) begin
          ram_st_d = STS_RAM_IDLE;
        end
      end
    endcase
  end

  // memory array, no reset needed
  always_ff @(posedge clock_in) begin
    if (ram_st_q == STS_RAM_WRITE) begin
      mem[ram_addr_q] <= pattern(ram_addr_q, ram_seed_q);
    end
  end

  // ****************************************
  // periodic evaluation and flags
  // ****************************************
  always_comb begin
    check_now = tick10_if.tick | force_q;
    warn_set = 16'h0000;
    fail_set = 16'h0000;
    if (check_now) begin
      warn_set[`STS_W_CHAN] = |chan_hi;
      warn_set[`STS_W_MOFS] = master_offset_uv_in > `STS_OFS_MST_WARN_UV;
      fail_set[`STS_F_MOFS] = master_offset_uv_in > `STS_OFS_MST_FAIL_UV;
      warn_set[`STS_W_P5] = outside(p5_mv_in, `STS_P5_WARN_LO, `STS_P5_WARN_HI);
      fail_set[`STS_F_P5] = outside(p5_mv_in, `STS_P5_FAIL_LO, `STS_P5_FAIL_HI);
      warn_set[`STS_W_P12] = outside(p12_mv_in, `STS_12_WARN_LO, `STS_12_WARN_HI);
      warn_set[`STS_W_N12] = outside(n12_mv_in, `STS_12_WARN_LO, `STS_12_WARN_HI);
      fail_set[`STS_F_P12] = outside(p12_mv_in, `STS_12_FAIL_LO, `STS_12_FAIL_HI);
      fail_set[`STS_F_N12] = outside(n12_mv_in, `STS_12_FAIL_LO, `STS_12_FAIL_HI);
      warn_set[`STS_W_P15] = outside(p15_mv_in, `STS_15_WARN_LO, `STS_15_WARN_HI);
      warn_set[`STS_W_N15] = outside(n15_mv_in, `STS_15_WARN_LO, `STS_15_WARN_HI);
      fail_set[`STS_F_P15] = outside(p15_mv_in, `STS_15_FAIL_LO, `STS_15_FAIL_HI);
      fail_set[`STS_F_N15] = outside(n15_mv_in, `STS_15_FAIL_LO, `STS_15_FAIL_HI);
      warn_set[`STS_W_BATT] = outside(batt_mv_in, `STS_BATT_LO, `STS_BATT_HI);
      fail_set[`STS_F_ROM] = rom_sum_in != rom_ref_in;
      fail_set[`STS_F_ACT] = active_settings_checksum_in != active_settings_ref_in;
      fail_set[`STS_F_NV] = nv_settings_checksum_in != nv_settings_ref_in;
    end
    warn_set[`STS_W_CHG] = charger_err_in;
    fail_set[`STS_F_RAM] = ram_bad;
    fail_set[`STS_F_CONV] = conv_short;
    fail_set[`STS_F_XTAL] = xtal_stop;
    fail_set[`STS_F_TRAP] = trap_valid_in;
    new_fail = fail_set & ~fail_q;
    // a warning raised in the clearing cycle survives the clear
    warn_clr = (wr_in && addr_in == `STS_ADDR_WARN) ? wr_data_in[15:0] : 16'h0000;
    warn_d = (warn_q & ~warn_clr) | warn_set;
    fail_d = fail_q | fail_set;
    force_d = wr_in && addr_in == `STS_ADDR_CTRL && wr_data_in[`STS_CTRL_FORCE];
    trap_d = trap_valid_in ? trap_code_in : trap_q;
  end

  // ****************************************
  // protection gating, alarm, report, display
  // ****************************************
  always_comb begin
    prot_d = ~|fail_d;
    trip_d = prot_d & trip_req_in;
    close_d = prot_d & close_req_in;
    cont_d = prot_d ? contact_req_in : '0;
    led_d = prot_d;
    // a fresh warning restarts the pulse rather than stacking
    if (|warn_set) begin
      alarm_cnt_d = PULSE_CYCLES;
    end else if (alarm_cnt_q != 32'h0) begin
      alarm_cnt_d = alarm_cnt_q - 32'h1;
    end else begin
      alarm_cnt_d = alarm_cnt_q;
    end
    coil_d = prot_d && (alarm_cnt_d == 32'h0);
    report_d = (|warn_set) || (|new_fail);
    dvalid_d = |new_fail;
    dkind_d = dkind_q;
    darg_d = darg_q;
    if (new_fail[`STS_F_XTAL]) begin
      dkind_d = STS_MSG_OSC;
      darg_d = 8'h00;
    end else if (new_fail[`STS_F_TRAP]) begin
      dkind_d = STS_MSG_TRAP;
      darg_d = trap_code_in;
    end else if (|new_fail) begin
      dkind_d = STS_MSG_FAIL;
      darg_d = lowest(new_fail);
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  always_comb begin
    rd_d = 32'h0;
    if (rd_in) begin
      unique case (addr_in)
        `STS_ADDR_WARN: rd_d = {16'h0000, warn_q};
        `STS_ADDR_FAIL: rd_d = {16'h0000, fail_q};
        `STS_ADDR_CTRL: rd_d = {29'h0, ram_st_q != STS_RAM_IDLE, coil_q, prot_q};
        `STS_ADDR_TRAP: rd_d = {24'h000000, trap_q};
        default: rd_d = 32'h0;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      warn_q <= 16'h0000;
      fail_q <= 16'h0000;
      force_q <= 1'b0;
      trap_q <= 8'h00;
      rd_q <= 32'h0;
      alarm_cnt_q <= 32'h0;
      conv_cnt_q <= 8'h00;
      conv_arm_q <= 1'b0;
      xtal_cnt_q <= 16'h0000;
      osc_prev_q <= 1'b0;
      prot_q <= 1'b0;
      trip_q <= 1'b0;
      close_q <= 1'b0;
      cont_q <= '0;
      led_q <= 1'b0;
      coil_q <= 1'b0;
      report_q <= 1'b0;
      dvalid_q <= 1'b0;
      dkind_q <= STS_MSG_NONE;
      darg_q <= 8'h00;
      ram_st_q <= STS_RAM_IDLE;
      ram_addr_q <= '0;
      ram_seed_q <= 1'b0;
      ram_tick_q <= 8'h00;
    end else begin
      warn_q <= warn_d;
      fail_q <= fail_d;
      force_q <= force_d;
      trap_q <= trap_d;
      rd_q <= rd_d;
      alarm_cnt_q <= alarm_cnt_d;
      conv_cnt_q <= conv_cnt_d;
      conv_arm_q <= conv_arm_d;
      xtal_cnt_q <= xtal_cnt_d;
      osc_prev_q <= osc_prev_d;
      prot_q <= prot_d;
      trip_q <= trip_d;
      close_q <= close_d;
      cont_q <= cont_d;
      led_q <= led_d;
      coil_q <= coil_d;
      report_q <= report_d;
      dvalid_q <= dvalid_d;
      dkind_q <= dkind_d;
      darg_q <= darg_d;
      ram_st_q <= ram_st_d;
      ram_addr_q <= ram_addr_d;
      ram_seed_q <= ram_seed_d;
      ram_tick_q <= ram_tick_d;
    end
  end

  assign rd_data_out = rd_q;
  assign prot_en_out = prot_q;
  assign trip_drive_out = trip_q;
  assign close_drive_out = close_q;
  assign contact_drive_out = cont_q;
  assign en_led_out = led_q;
  assign alarm_coil_out = coil_q;
  assign report_out = report_q;
  assign disp_valid_out = dvalid_q;
  assign disp_kind_out = dkind_q;
  assign disp_arg_out = darg_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  // length of the current coil-off run
  logic [31:0] low_run_q;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_run_q <= 32'(PULSE_MIN); // power-up rise of the coil counts as a full run
    end else begin
      low_run_q <= coil_q ? 32'h0 : low_run_q + 32'h1;
    end
  end

  property p_fail_kills_prot;
    (|fail_set) |=> !prot_en_out ##1 !prot_en_out;
  endproperty
  a_fail_kills_prot: assert property (p_fail_kills_prot) else $error("prot stayed on");
  property p_drives_off;
    !prot_en_out |-> !trip_drive_out && !close_drive_out && contact_drive_out == '0;
  endproperty
  a_drives_off: assert property (p_drives_off) else $error("drive while disabled");
  property p_led;
    en_led_out == prot_en_out;
  endproperty
  a_led: assert property (p_led) else $error("indicator disagrees");
  property p_latched_alarm;
    (|fail_q) |-> !alarm_coil_out;
  endproperty
  a_latched_alarm: assert property (p_latched_alarm) else $error("coil on after fail");
  property p_pulse_len;
    $rose(alarm_coil_out) |-> low_run_q >= 32'(PULSE_MIN);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("alarm pulse short");
  property p_report;
    (|warn_set) |=> report_out;
  endproperty
  a_report: assert property (p_report) else $error("no status report");
  property p_disp;
    (|new_fail) |=> disp_valid_out && disp_kind_out != STS_MSG_NONE;
  endproperty
  a_disp: assert property (p_disp) else $error("no failure message");
  property p_master_ofs;
    check_now && master_offset_uv_in > `STS_OFS_MST_FAIL_UV |=>
      fail_q[`STS_F_MOFS] && !prot_en_out;
  endproperty
  a_master_ofs: assert property (p_master_ofs) else $error("offset fail missed");
  property p_batt_warn;
    check_now && batt_mv_in < `STS_BATT_LO && fail_q == 16'h0000 && fail_set == 16'h0000 |=>
      warn_q[`STS_W_BATT] && prot_en_out && !alarm_coil_out;
  endproperty
  a_batt_warn: assert property (p_batt_warn) else $error("battery warn wrong");
  property p_trap_msg;
    trap_valid_in && !fail_q[`STS_F_TRAP] && !xtal_stop |=>
      disp_kind_out == STS_MSG_TRAP && disp_arg_out == $past(trap_code_in);
  endproperty
  a_trap_msg: assert property (p_trap_msg) else $error("trap message wrong");
  property p_sticky;
    1'b1 |=> (fail_q & $past(fail_q)) == $past(fail_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("failure flag dropped");

  c_warn_pulse: cover property ($rose(alarm_coil_out) && fail_q == 16'h0000);
  c_trap: cover property (disp_valid_out && disp_kind_out == STS_MSG_TRAP);
  c_ram_pass: cover property (ram_st_q == STS_RAM_READ ##1 ram_st_q == STS_RAM_IDLE);
endmodule : sts_selftest_supervisor

// ### sts_params.svh
`ifndef STS_PARAMS_SVH
`define STS_PARAMS_SVH
// ****************************************
// register map (byte addresses)
// ****************************************
`define STS_ADDR_W 4
`define STS_ADDR_WARN 4'h0
`define STS_ADDR_FAIL 4'h4
`define STS_ADDR_CTRL 4'h8
`define STS_ADDR_TRAP 4'hC
`define STS_CTRL_FORCE 0
`define STS_CTRL_PROT 0
`define STS_CTRL_COIL 1
`define STS_CTRL_BUSY 2
// ****************************************
// warning bit positions
// ****************************************
`define STS_W_CHAN 0
`define STS_W_MOFS 1
`define STS_W_P5 2
`define STS_W_P12 3
`define STS_W_N12 4
`define STS_W_P15 5
`define STS_W_N15 6
`define STS_W_BATT 7
`define STS_W_CHG 8
// ****************************************
// failure bit positions
// ****************************************
`define STS_F_MOFS 0
`define STS_F_P5 1
`define STS_F_P12 2
`define STS_F_N12 3
`define STS_F_P15 4
`define STS_F_N15 5
`define STS_F_RAM 6
`define STS_F_ROM 7
`define STS_F_ACT 8
`define STS_F_NV 9
`define STS_F_CONV 10
`define STS_F_XTAL 11
`define STS_F_TRAP 12
// ****************************************
// limits: offsets in uV, rails in mV
// ****************************************
`define STS_OFS_CHAN_WARN_UV 16'h7530
`define STS_OFS_MST_WARN_UV 16'h4E20
`define STS_OFS_MST_FAIL_UV 16'h7530
`define STS_P5_WARN_LO 16'h12C0
`define STS_P5_WARN_HI 16'h1450
`define STS_P5_FAIL_LO 16'h122A
`define STS_P5_FAIL_HI 16'h1518
`define STS_12_WARN_LO 16'h2CEC
`define STS_12_WARN_HI 16'h30D4
`define STS_12_FAIL_LO 16'h2BC0
`define STS_12_FAIL_HI 16'h36B0
`define STS_15_WARN_LO 16'h3840
`define STS_15_WARN_HI 16'h3CF0
`define STS_15_FAIL_LO 16'h36B0
`define STS_15_FAIL_HI 16'h3E80
`define STS_BATT_LO 16'h4650
`define STS_BATT_HI 16'hAFC8
// ****************************************
// timing and sizes
// ****************************************
`define STS_CLK_HZ 100000000
`define STS_CLK_PERIOD_NS 10
`define STS_CHECK_PERIOD_S 10
`define STS_RAM_PERIOD_S 60
`define STS_ALARM_PULSE_S 5
`define STS_XTAL_TIMEOUT_NS 1000
`define STS_CONV_PER_QTR 4
`define STS_NCHAN 8
`define STS_NCONT 4
`define STS_RAM_DEPTH 16
`define STS_SEED_A 16'hA5A5
`define STS_SEED_B 16'h5A5A
`endif

// ### sts_pkg.sv
package sts_pkg;
  // display message kinds
  typedef enum logic [1:0] {
    STS_MSG_NONE,
    STS_MSG_FAIL,
    STS_MSG_OSC,
    STS_MSG_TRAP
  } sts_msg_t;
  // memory test sequencer
  typedef enum logic [1:0] {
    STS_RAM_IDLE,
    STS_RAM_WRITE,
    STS_RAM_READ
  } sts_ram_state_t;
endpackage : sts_pkg

// ### sts_tick_if.sv
`timescale 1ns/10ps
interface sts_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : sts_tick_if

// ### sts_divider.sv
`timescale 1ns/10ps
module sts_divider
  import sts_pkg::*;
#(
  parameter int unsigned DIV = 1000
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  sts_tick_if.src tick_if
);
  if (DIV < 2) begin : g_bad
    $error("sts_divider: DIV must be at least 2");
  end
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic tick_q;
  logic tick_d;
  // free running count, one-cycle pulse at wrap
  always_comb begin
    tick_d = (cnt_q == 32'(DIV - 1));
    cnt_d = tick_d ? 32'h0 : cnt_q + 32'h1;
  end
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign tick_if.tick = tick_q;
endmodule : sts_divider

// ### sts_term_model.sv
`timescale 1ns/10ps
// ****
// serial terminal and alarm circuit
// ****
module sts_term_model (
  input wire logic clock_in,
  input wire logic report_in,
  input wire logic coil_in,
  output int n_reports_out,
  output logic nc_closed_out
);
  // each report pulse stands for one unsolicited frame on the port
  int n_q = 0;
  always @(posedge clock_in) begin
    if (report_in === 1'b1) begin
      n_q <= n_q + 1;
    end
  end
  assign n_reports_out = n_q;
  // normally closed contact: closes on alarm and on power loss alike
  assign nc_closed_out = !coil_in;
endmodule : sts_term_model

// ### sts_selftest_supervisor_bench.sv
`timescale 1ns/10ps
module sts_selftest_supervisor_bench;
  import sts_pkg::*;
  // ****
  // signals
  // ****
  localparam int unsigned PULSE = 50;
  localparam logic [15:0] BADV [16] = '{16'h61A8, 16'h125C, 16'h2C88, 16'h3138, 16'h37DC,
    16'h3D54, 16'h4268, 16'h7918, 16'h11F8, 16'h2B5C, 16'h3714, 16'h364C, 16'h3EE4, 0, 0, 0};
  localparam int EXPB [19] = '{1, 2, 3, 4, 5, 6, 7, 0, 1, 2, 3, 4, 5, 7, 8, 9, 12, 11, 10};
  logic clock_in, nrst_in = 0, wr_in = 0, rd_in = 0, trap_valid_in = 0, charger_err_in = 0;
  logic [3:0] addr_in = 0, contact_req_in = 4'hF, contact_drive_out, gen_q = 0;
  logic [31:0] wr_data_in = 0, rd_data_out, rdv;
  logic [7:0][15:0] chan_offset_uv_in = '0;
  logic [15:0] master_offset_uv_in = 0, p5_mv_in = 16'h1388, batt_mv_in = 16'h5DC0;
  logic [15:0] p12_mv_in = 16'h2EE0, n12_mv_in = 16'h2EE0, p15_mv_in = 16'h3A98;
  logic [15:0] n15_mv_in = 16'h3A98, rom_sum_in = 0, rom_ref_in = 0;
  logic [15:0] active_settings_checksum_in = 0, active_settings_ref_in = 0;
  logic [15:0] nv_settings_checksum_in = 0, nv_settings_ref_in = 0;
  logic conv_done_in = 0, quarter_cycle_in = 0, osc_probe_in = 0, osc_en = 1, conv_en = 1;
  logic [7:0] trap_code_in = 0, disp_arg_out;
  logic trip_req_in = 1, close_req_in = 1, prot_en_out, trip_drive_out, close_drive_out;
  logic en_led_out, alarm_coil_out, report_out, disp_valid_out, nc_closed;
  sts_msg_t disp_kind_out;
  int num_errors = 0, n_compared = 0, n_rep;
  // short counts keep the run small
  sts_selftest_supervisor #(.CHECK_CYCLES(2000), .PULSE_CYCLES(PULSE)) dut (.*);
  sts_term_model term (.clock_in(clock_in), .report_in(report_out), .coil_in(alarm_coil_out),
    .n_reports_out(n_rep), .nc_closed_out(nc_closed));
  // 100 MHz clock
  initial begin
    clock_in = 0;
    forever #5 clock_in = ~clock_in;
  end
  // crystal probe and converter: 8 conversions per quarter cycle
  always @(posedge clock_in) begin
    gen_q <= gen_q + 4'h1;
    osc_probe_in <= osc_en ? gen_q[2] : osc_probe_in;
    conv_done_in <= conv_en & gen_q[0];
    quarter_cycle_in <= (gen_q == 4'hF);
  end
  // ****
  // tasks
  // ****
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1;
    @(posedge clock_in);
    wr_in <= 0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1;
    @(posedge clock_in);
    rd_in <= 0;
    #1 d = rd_data_out;
  endtask : rd
  task force_chk;
    wr(4'h8, 32'h1);
    repeat (3) @(posedge clock_in);
    #1;
  endtask : force_chk
  task apply(input int k, input logic bad);
    @(posedge clock_in);
    case (k)
      0, 7: master_offset_uv_in <= bad ? BADV[k] : 16'h0000;
      1, 8: p5_mv_in <= bad ? BADV[k] : 16'h1388;
      2, 9: p12_mv_in <= bad ? BADV[k] : 16'h2EE0;
      3, 10: n12_mv_in <= bad ? BADV[k] : 16'h2EE0;
      4, 11: p15_mv_in <= bad ? BADV[k] : 16'h3A98;
      5, 12: n15_mv_in <= bad ? BADV[k] : 16'h3A98;
      6: batt_mv_in <= bad ? BADV[k] : 16'h5DC0;
      13: rom_ref_in <= {15'h0000, bad};
      14: active_settings_ref_in <= {15'h0000, bad};
      default: nv_settings_ref_in <= {15'h0000, bad};
    endcase
  endtask : apply
  // first periodic check comes a full period after release
  task t_tick;
    int n;
    n = 0;
    chk({prot_en_out, en_led_out, alarm_coil_out, trip_drive_out, contact_drive_out}, 8'hFF);
    @(posedge clock_in);
    chan_offset_uv_in[5] <= 16'h7918;
    while (n_rep == 0 && n < 2100) begin
      @(posedge clock_in);
      n++;
    end
    chk(n > 1990 && n < 2010, 1'b1);
    chan_offset_uv_in[5] <= 16'h0000;
    rd(4'h0, rdv);
    chk(rdv, 32'h1);
    wr(4'h0, 32'h1);
    rd(4'h0, rdv);
    chk(rdv, 32'h0);
  endtask : t_tick
  // warnings leave protection on and drop the coil for one pulse
  task t_warn;
    int r;
    for (int k = 0; k < 7; k++) begin
      r = n_rep;
      apply(k, 1'b1);
      force_chk;
      chk({prot_en_out, alarm_coil_out}, 2'b10);
      apply(k, 1'b0);
      rd(4'h0, rdv);
      chk(rdv, 32'h1 << EXPB[k]);
      chk(n_rep, r + 1);
      wr(4'h0, 32'h1FF);
    end
    repeat (PULSE - 20) @(posedge clock_in);
    chk({alarm_coil_out, nc_closed}, 2'b01);
    repeat (30) @(posedge clock_in);
    chk(alarm_coil_out, 1'b1);
    charger_err_in <= 1;
    @(posedge clock_in);
    charger_err_in <= 0;
    rd(4'h0, rdv);
    chk({rdv[30:0], prot_en_out}, 32'h201);
    rd(4'h2, rdv);
    chk(rdv, 32'h0);
    chk({disp_valid_out, disp_kind_out}, 3'b000);
  endtask : t_warn
  // each failure case starts from a fresh restart
  task t_fail(input int k);
    int r;
    sts_msg_t kind;
    kind = k == 16 ? STS_MSG_TRAP : k == 17 ? STS_MSG_OSC : STS_MSG_FAIL;
    @(posedge clock_in);
    nrst_in <= 0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1;
    r = n_rep;
    case (k)
      16: begin
        trap_code_in <= 8'h3C;
        trap_valid_in <= 1;
        @(posedge clock_in);
        trap_valid_in <= 0;
        #1 chk(disp_valid_out, 1'b1);
        repeat (2) @(posedge clock_in);
        chk(disp_valid_out, 1'b0);
      end
      17: osc_en <= 0;
      18: conv_en <= 0;
      default: apply(k, 1'b1);
    endcase
    if (k < 16) force_chk;
    else repeat (120) @(posedge clock_in);
    wr(4'h4, 32'hFFFF_FFFF);
    rd(4'h4, rdv);
    chk(rdv, 32'h1 << EXPB[k]);
    chk({prot_en_out, en_led_out, trip_drive_out, close_drive_out, contact_drive_out}, 0);
    chk({disp_kind_out, disp_arg_out}, {kind, k == 16 ? 8'h3C : k == 17 ? 8'h00 : 8'(EXPB[k])});
    chk(n_rep > r, 1'b1);
    if (k == 16) begin
      rd(4'hC, rdv);
      chk(rdv, 32'h3C);
    end
    if (k < 16) apply(k, 1'b0);
    osc_en <= 1;
    conv_en <= 1;
    force_chk;
    repeat (PULSE + 10) @(posedge clock_in);
    chk({prot_en_out, alarm_coil_out}, 2'b00);
  endtask : t_fail
  task tally_and_finish;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // ****
  // sequence
  // ****
  initial begin
    repeat (2) @(posedge clock_in);
    nrst_in <= 1;
    @(posedge clock_in);
    #1;
    t_tick;
    t_warn;
    for (int k = 7; k < 19; k++) t_fail(k);
    tally_and_finish;
  end
  // run takes about 3500 cycles; cut a hang well beyond that
  initial begin
    #200000;
    num_errors++;
    tally_and_finish;
  end
endmodule : sts_selftest_supervisor_bench
